// file: cp_monitor_mode_error_exit.sv
// monitor-mode error exit logic with apb register slave
// What this block does
// - selected out-of-range incremental write is blocked, memory unchanged.
// - unselected out-of-range incremental write is suppressed; execution continues.
// - selected out-of-range write leaves the bad address held.
// - after saving exit record, interrupt to executive state then halt.
// - out-of-range fetch or branch inhibits execution, stores code 01 with target.
// - out-of-range fetch or branch exits regardless of range exit mode bit.
// - compare/move flags range error on char position over 9 or operand out of range.
// - bad char position skips memory access; bad operand leaves instruction unexecuted.
// - extended memory failure on 011/012 passes; unselected resumes next word.
// - extended memory failure on 014/015 unselected passes, resumes next parcel.
// - selected extended memory failure passes, stores P and 01, interrupts, halts.
// - infinite code 02, indefinite 04; selected stores and halts, else continues.
// - parity or double-bit memory error always interrupts and halts.
// - hardware error records P with code 20 at the exit location.
// - exit code field is six bits with fixed code assignments.
// - exit mode bits come from the loaded exchange package fourth word; here an APB write to OFF_EXIT_MODE sets them.
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "cp_exit_consts.svh"
module cp_monitor_mode_error_exit #(
  parameter int AW = 18
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic monitor_flag,
  input wire logic instr_done,
  input wire cp_exit_pkg::cm_addr_t p_addr,
  input wire logic incr_write_req,
  input wire cp_exit_pkg::cm_addr_t incr_write_addr,
  input wire logic next_instruction_fetch,
  input wire cp_exit_pkg::cm_addr_t fetch_addr,
  input wire logic compare_move_unit,
  input wire logic [3:0] first_char_position,
  input wire logic [3:0] second_char_position,
  input wire cp_exit_pkg::cm_addr_t first_operand_address,
  input wire cp_exit_pkg::cm_addr_t second_operand_address,
  input wire logic extended_memory,
  input wire logic [8:0] uem_opcode,
  input wire logic uem_range_fail,
  input wire logic fp_infinite,
  input wire logic fp_indefinite,
  input wire logic hw_parity_error,
  input wire logic double_bit_error,
  output logic cm_write_allow,
  output logic inhibit_execution,
  output logic cmu_skip_memory,
  output logic uem_pass,
  output logic resume_next_word,
  output logic resume_next_parcel,
  output logic exit_record_write,
  output cp_exit_pkg::cm_addr_t exit_record_location,
  output logic [23:0] exit_record_data,
  output cp_exit_pkg::cm_addr_t out_of_range_address,
  output logic exec_interrupt,
  output logic cpu_halted,
  output logic irq
);
  import cp_exit_pkg::*;

  exit_state_t state, next_state;
  logic [2:0] exit_mode_selection, next_exit_mode_selection;
  cm_addr_t field_len, next_field_len;
  cm_addr_t rec_loc, next_rec_loc;
  cm_addr_t oor, next_oor;
  logic [23:0] rec, next_rec;
  logic [4:0] status, next_status, mask, next_mask;
  logic rec_wr, next_rec_wr, xint, next_xint;
  logic [31:0] rdata, next_rdata;
  logic wr_ok, fe_ok, k1_ok, k2_ok;
  logic active, wr_oor, fe_oor, cmu_char, cmu_op, uem_oor, uem_word_op;
  logic range_err, range_exit, hw_err, inf_exit, indef_exit, take;
  logic [4:0] events;
  exit_code_t code;
  cm_addr_t saved_p;
  logic apb_wr, apb_rd, resume;

  // one comparator per address that the block guards
  range_check #(.AW(AW)) u_wr_chk (.addr(incr_write_addr), .limit(field_len), .in_range(wr_ok));
  range_check #(.AW(AW)) u_fe_chk (.addr(fetch_addr), .limit(field_len), .in_range(fe_ok));
  range_check #(.AW(AW)) u_k1_chk (.addr(first_operand_address), .limit(field_len), .in_range(k1_ok));
  range_check #(.AW(AW)) u_k2_chk (.addr(second_operand_address), .limit(field_len), .in_range(k2_ok));

  // a halted processor executes nothing, so detection only runs from idle
  assign active = monitor_flag && (state == ST_IDLE) && instr_done;
  assign wr_oor = active && incr_write_req && !wr_ok;
  assign fe_oor = active && next_instruction_fetch && !fe_ok;
  assign cmu_char = active && compare_move_unit &&
                    ((first_char_position > `CHAR_POS_MAX) || (second_char_position > `CHAR_POS_MAX));
  assign cmu_op = active && compare_move_unit && (!k1_ok || !k2_ok);
  assign uem_word_op = (uem_opcode == `UEM_OP_RE) || (uem_opcode == `UEM_OP_WE);
  assign uem_oor = active && extended_memory && uem_range_fail &&
                   (uem_word_op || (uem_opcode == `UEM_OP_RX) || (uem_opcode == `UEM_OP_WX));
  assign range_err = wr_oor || fe_oor || cmu_char || cmu_op || uem_oor;
  assign range_exit = fe_oor ||
                      ((wr_oor || cmu_char || cmu_op || uem_oor) && exit_mode_selection[`EM_RANGE]);
  assign hw_err = active && (hw_parity_error || double_bit_error);
  assign inf_exit = active && fp_infinite && exit_mode_selection[`EM_INF];
  assign indef_exit = active && fp_indefinite && exit_mode_selection[`EM_INDEF];
  assign take = hw_err || range_exit || inf_exit || indef_exit;

  assign cm_write_allow = incr_write_req && !wr_oor;
  assign inhibit_execution = fe_oor || cmu_op;
  assign cmu_skip_memory = cmu_char || cmu_op;
  assign uem_pass = uem_oor;
  assign resume_next_word = uem_oor && uem_word_op && !take;
  assign resume_next_parcel = uem_oor && !uem_word_op && !take;

  // fixed priority for the code field: hardware error, then range, then infinite, then indefinite
  always_comb begin
    if (hw_err) begin
      code = `EC_CPU_MALF;
    end else if (range_exit) begin
      code = `EC_RANGE;
    end else if (inf_exit) begin
      code = `EC_INF;
    end else begin
      code = `EC_INDEF;
    end
    saved_p = (!hw_err && fe_oor) ? fetch_addr : p_addr;
  end

  assign events = {1'b0, hw_err, active && fp_indefinite, active && fp_infinite, range_err};
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !penable && !pwrite;
  assign resume = apb_wr && (paddr == `OFF_CTRL) && pwdata[0];

  // exit sequence: store record, interrupt to executive state, halt
  always_comb begin
    next_state = state;
    next_rec = rec;
    next_rec_wr = 1'b0;
    next_xint = 1'b0;
    next_oor = oor;
    case (state)
      ST_IDLE: begin
        if (take) begin
          next_state = ST_STORE;
          next_rec = {code, saved_p};
          next_rec_wr = 1'b1;
        end
        if (wr_oor && exit_mode_selection[`EM_RANGE]) begin
          next_oor = incr_write_addr;
        end
      end
      ST_STORE: begin
        next_state = ST_XCHG;
        next_xint = 1'b1;
      end
      ST_XCHG: next_state = ST_HALT;
      ST_HALT: begin
        if (resume) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // register file: writes on access phase, read data latched in setup
  always_comb begin
    next_exit_mode_selection = exit_mode_selection;
    next_field_len = field_len;
    next_rec_loc = rec_loc;
    next_mask = mask;
    next_status = status | events | {next_state == ST_HALT && state != ST_HALT, 4'h0};
    next_rdata = rdata;
    if (apb_wr) begin
      case (paddr)
        `OFF_EXIT_MODE: next_exit_mode_selection = pwdata[2:0];
        `OFF_FIELD_LEN: next_field_len = pwdata[17:0];
        `OFF_REC_LOC: next_rec_loc = pwdata[17:0];
        `OFF_MASK: next_mask = pwdata[4:0];
        // set wins over the write-one clear
        `OFF_STATUS: next_status = (status & ~pwdata[4:0]) | events |
                                   {next_state == ST_HALT && state != ST_HALT, 4'h0};
        default: ;
      endcase
    end
    if (apb_rd) begin
      case (paddr)
        `OFF_CTRL: next_rdata = 32'h0;
        `OFF_EXIT_MODE: next_rdata = {29'h0, exit_mode_selection};
        `OFF_FIELD_LEN: next_rdata = {14'h0, field_len};
        `OFF_REC_LOC: next_rdata = {14'h0, rec_loc};
        `OFF_EXIT_REC: next_rdata = {8'h0, rec};
        `OFF_OOR_ADDR: next_rdata = {14'h0, oor};
        `OFF_STATUS: next_rdata = {27'h0, status};
        `OFF_MASK: next_rdata = {27'h0, mask};
        `OFF_STATE: next_rdata = {30'h0, state};
        default: next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      rec <= 24'h0;
      rec_wr <= 1'b0;
      xint <= 1'b0;
      oor <= 18'h0;
      exit_mode_selection <= 3'h0;
      field_len <= `RST_FIELD_LEN;
      rec_loc <= 18'h0;
      mask <= 5'h0;
      status <= 5'h0;
      rdata <= 32'h0;
    end else begin
      state <= next_state;
      rec <= next_rec;
      rec_wr <= next_rec_wr;
      xint <= next_xint;
      oor <= next_oor;
      exit_mode_selection <= next_exit_mode_selection;
      field_len <= next_field_len;
      rec_loc <= next_rec_loc;
      mask <= next_mask;
      status <= next_status;
      rdata <= next_rdata;
    end
  end

  assign prdata = rdata;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign exit_record_write = rec_wr;
  assign exit_record_data = rec;
  assign exit_record_location = rec_loc;
  assign out_of_range_address = oor;
  assign exec_interrupt = xint;
  assign cpu_halted = (state == ST_HALT);
  assign irq = |(status & mask);

  sequence s_exit_walk;
    state == ST_STORE ##1 state == ST_XCHG && exec_interrupt ##1 state == ST_HALT;
  endsequence

  property p_write_blocked;
    @(posedge pclk) disable iff (!presetn)
      (active && incr_write_req && incr_write_addr >= field_len) |-> !cm_write_allow;
  endproperty
  a_write_blocked: assert property (p_write_blocked) else $error("out of range write reached memory");

  property p_write_continue;
    @(posedge pclk) disable iff (!presetn) (wr_oor && !take) |=> state == ST_IDLE && !exit_record_write;
  endproperty
  a_write_continue: assert property (p_write_continue) else $error("unselected write error stopped cpu");

  property p_oor_held;
    @(posedge pclk) disable iff (!presetn)
      (wr_oor && exit_mode_selection[0]) |=> out_of_range_address == $past(incr_write_addr);
  endproperty
  a_oor_held: assert property (p_oor_held) else $error("bad address not held");

  property p_exit_walk;
    @(posedge pclk) disable iff (!presetn) take |=> exit_record_write ##0 s_exit_walk;
  endproperty
  a_exit_walk: assert property (p_exit_walk) else $error("exit sequence broken");

  property p_fetch_code;
    @(posedge pclk) disable iff (!presetn)
      (fe_oor && !hw_err) |-> inhibit_execution ##1 exit_record_data == {6'h01, $past(fetch_addr)};
  endproperty
  a_fetch_code: assert property (p_fetch_code) else $error("fetch exit record wrong");

  property p_fetch_uncond;
    @(posedge pclk) disable iff (!presetn) (fe_oor && !exit_mode_selection[0]) |=> state == ST_STORE;
  endproperty
  a_fetch_uncond: assert property (p_fetch_uncond) else $error("fetch error did not exit");

  property p_cmu_char;
    @(posedge pclk) disable iff (!presetn)
      (active && compare_move_unit &&
       (first_char_position > `CHAR_POS_MAX || second_char_position > `CHAR_POS_MAX)) |-> range_err && cmu_skip_memory;
  endproperty
  a_cmu_char: assert property (p_cmu_char) else $error("char position error missed");

  property p_indef_code;
    @(posedge pclk) disable iff (!presetn)
      (indef_exit && !hw_err && !range_exit && !inf_exit) |=> exit_record_data[23:18] == 6'h04;
  endproperty
  a_indef_code: assert property (p_indef_code) else $error("indefinite code wrong");

  property p_hw_halt;
    @(posedge pclk) disable iff (!presetn) hw_err |=> ##2 cpu_halted [*2];
  endproperty
  a_hw_halt: assert property (p_hw_halt) else $error("hardware error did not halt");

  property p_hw_code;
    @(posedge pclk) disable iff (!presetn) hw_err |=> exit_record_data[23:18] == 6'h10;
  endproperty
  a_hw_code: assert property (p_hw_code) else $error("hardware error code wrong");
endmodule : cp_monitor_mode_error_exit
`default_nettype wire

// file: cp_exit_consts.svh
// offsets, field positions, reset values and exit codes of the monitor-mode error-exit block
`ifndef CP_EXIT_CONSTS_SVH
`define CP_EXIT_CONSTS_SVH
`define OFF_CTRL 8'h00
`define OFF_EXIT_MODE 8'h04
`define OFF_FIELD_LEN 8'h08
`define OFF_REC_LOC 8'h0C
`define OFF_EXIT_REC 8'h10
`define OFF_OOR_ADDR 8'h14
`define OFF_STATUS 8'h18
`define OFF_MASK 8'h1C
`define OFF_STATE 8'h20
`define EM_RANGE 0
`define EM_INF 1
`define EM_INDEF 2
`define ST_RANGE 0
`define ST_INF 1
`define ST_INDEF 2
`define ST_HW 3
`define ST_HALT 4
`define EC_ILLEGAL 6'h00
`define EC_RANGE 6'h01
`define EC_INF 6'h02
`define EC_INDEF 6'h04
`define EC_CPU_MALF 6'h10
`define EC_HW_MALF 6'h37
`define CHAR_POS_MAX 4'h9
`define UEM_OP_RE 9'h009
`define UEM_OP_WE 9'h00A
`define UEM_OP_RX 9'h00C
`define UEM_OP_WX 9'h00D
`define RST_FIELD_LEN 18'h3FFFF
`endif

// file: cp_exit_pkg.sv
// types shared by the error-exit block
package cp_exit_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_STORE = 2'h1,
    ST_XCHG = 2'h3,
    ST_HALT = 2'h2
  } exit_state_t;
  typedef logic [17:0] cm_addr_t;
  typedef logic [5:0] exit_code_t;
endpackage : cp_exit_pkg

// file: range_check.sv
// address against field-length comparison
`timescale 1ns/1ps
`default_nettype none
module range_check #(
  parameter int AW = 18
) (
  input wire logic [AW-1:0] addr,
  input wire logic [AW-1:0] limit,
  output logic in_range
);
  assign in_range = addr < limit;
endmodule : range_check
`default_nettype wire

// file: cm_exit_store.sv
// memory side of the exit path: keeps the last exit record and counts stores
`timescale 1ns/1ps
`default_nettype none
module cm_exit_store (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cm_write_allow,
  input wire logic exit_record_write,
  input wire logic [23:0] exit_record_data,
  output logic [7:0] wr_cnt,
  output logic [23:0] mem_word
);
  // a store lands only on an edge, as the memory takes it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_cnt <= 8'h00;
      mem_word <= 24'h000000;
    end else begin
      if (cm_write_allow) begin
        wr_cnt <= wr_cnt + 8'h01;
      end
      if (exit_record_write) begin
        mem_word <= exit_record_data;
      end
    end
  end
endmodule : cm_exit_store
`default_nettype wire

// file: cp_monitor_mode_error_exit_bench.sv
// self-checking bench for the monitor-mode error exit block
`timescale 1ns/1ps
`default_nettype none
`include "cp_exit_consts.svh"
module cp_monitor_mode_error_exit_bench;
  import cp_exit_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, monitor_flag, instr_done, incr_write_req, next_instruction_fetch;
  logic compare_move_unit, extended_memory, uem_range_fail, fp_infinite, fp_indefinite;
  logic hw_parity_error, double_bit_error, exit_record_write, exec_interrupt, cpu_halted, irq;
  logic cm_write_allow, inhibit_execution, cmu_skip_memory, uem_pass, resume_next_word, resume_next_parcel;
  logic [3:0] first_char_position, second_char_position;
  logic [8:0] uem_opcode;
  cm_addr_t p_addr, incr_write_addr, fetch_addr, first_operand_address, second_operand_address;
  cm_addr_t exit_record_location, out_of_range_address, a;
  logic [23:0] exit_record_data, mem_word;
  logic [7:0] wr_cnt;
  logic [7:0] ra [5] = '{`OFF_FIELD_LEN, `OFF_EXIT_MODE, `OFF_STATE, `OFF_STATUS, 8'h24};
  logic [31:0] rv [5] = '{32'(`RST_FIELD_LEN), 32'h0, 32'h0, 32'h0, 32'h0};
  logic [8:0] ops [4] = '{9'h009, 9'h00A, 9'h00C, 9'h00D};
  int err_total = 0;
  int n_tests = 0;
  int mode = 0;
  int fl = 'h100;
  always #25 pclk = ~pclk;
  cp_monitor_mode_error_exit u_cp_monitor_mode_error_exit (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .monitor_flag(monitor_flag),
    .instr_done(instr_done), .p_addr(p_addr), .incr_write_req(incr_write_req), .incr_write_addr(incr_write_addr),
    .next_instruction_fetch(next_instruction_fetch), .fetch_addr(fetch_addr),
    .compare_move_unit(compare_move_unit),
    .first_char_position(first_char_position), .second_char_position(second_char_position),
    .first_operand_address(first_operand_address), .second_operand_address(second_operand_address),
    .extended_memory(extended_memory), .uem_opcode(uem_opcode), .uem_range_fail(uem_range_fail),
    .fp_infinite(fp_infinite), .fp_indefinite(fp_indefinite), .hw_parity_error(hw_parity_error),
    .double_bit_error(double_bit_error), .cm_write_allow(cm_write_allow), .inhibit_execution(inhibit_execution),
    .cmu_skip_memory(cmu_skip_memory), .uem_pass(uem_pass), .resume_next_word(resume_next_word),
    .resume_next_parcel(resume_next_parcel), .exit_record_write(exit_record_write),
    .exit_record_location(exit_record_location), .exit_record_data(exit_record_data),
    .out_of_range_address(out_of_range_address), .exec_interrupt(exec_interrupt), .cpu_halted(cpu_halted),
    .irq(irq)
  );
  cm_exit_store u_cm_exit_store (
    .pclk(pclk), .presetn(presetn), .cm_write_allow(cm_write_allow), .exit_record_write(exit_record_write),
    .exit_record_data(exit_record_data), .wr_cnt(wr_cnt), .mem_word(mem_word)
  );
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      complete_run();
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic clr;
    instr_done <= 1'b0;
    monitor_flag <= 1'b1;
    {incr_write_req, next_instruction_fetch, compare_move_unit, extended_memory, uem_range_fail} <= 5'h0;
    {fp_infinite, fp_indefinite, hw_parity_error, double_bit_error} <= 4'h0;
    {first_char_position, second_char_position, uem_opcode} <= 17'h0;
    {incr_write_addr, fetch_addr, first_operand_address, second_operand_address} <= 72'h0;
    p_addr <= 18'($urandom_range(0, 'h3FFFF));
  endtask : clr
  // reference: exit code or -1, combinational responses, saved program address
  function automatic int model(output logic [5:0] cv, output cm_addr_t pv);
    bit fe, wr, cc, co, ue, hw, rg, x;
    fe = next_instruction_fetch && fetch_addr >= fl;
    wr = incr_write_req && incr_write_addr >= fl;
    cc = compare_move_unit && (first_char_position > 9 || second_char_position > 9);
    co = compare_move_unit && (first_operand_address >= fl || second_operand_address >= fl);
    ue = extended_memory && uem_range_fail && uem_opcode inside {9, 10, 12, 13};
    hw = hw_parity_error || double_bit_error;
    rg = fe || ((wr || cc || co || ue) && mode[0]);
    x = hw || rg || (fp_infinite && mode[1]) || (fp_indefinite && mode[2]);
    cv = {incr_write_req && !wr, fe || co, cc || co, ue, ue && !x && uem_opcode < 11, ue && !x && uem_opcode > 11};
    pv = fe ? fetch_addr : p_addr;
    if (!x || !monitor_flag) begin
      return -1;
    end
    return hw ? 'h10 : rg ? 1 : (fp_infinite && mode[1]) ? 2 : 4;
  endfunction : model
  task automatic fire;
    int code;
    logic [5:0] cv;
    cm_addr_t pv;
    logic [7:0] w0;
    logic [5:0] cs;
    // entered just after a rising edge: inputs and instr_done stand together for one cycle only
    instr_done <= 1'b1;
    @(negedge pclk);
    code = model(cv, pv);
    w0 = wr_cnt;
    cs = {cm_write_allow, inhibit_execution, cmu_skip_memory, uem_pass, resume_next_word, resume_next_parcel};
    chk(48'(cs), 48'(cv));
    @(posedge pclk);
    clr();
    @(negedge pclk);
    chk(48'({8'(wr_cnt - w0), exit_record_write}), 48'({7'h0, cv[5], code >= 0}));
    if (code >= 0) begin
      chk(48'({exit_record_data, exit_record_location}), 48'({code[5:0], pv, 18'h00040}));
    end
    @(negedge pclk);
    chk(48'(exec_interrupt), 48'(code >= 0));
    @(negedge pclk);
    chk(48'(cpu_halted), 48'(code >= 0));
    if (code >= 0) begin
      chk(48'(mem_word), 48'({code[5:0], pv}));
      apb(1'b1, `OFF_CTRL, 32'h1);
      repeat (2) @(negedge pclk);
      chk(48'(cpu_halted), 48'h0);
    end
    @(posedge pclk);
  endtask : fire
  initial begin
    void'($urandom(83));
    clr();
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ra[i]) begin
      apb(1'b0, ra[i], 32'h0);
      chk(48'({pslverr, rd}), 48'({1'b0, rv[i]}));
    end
    $display("reset values done");
    apb(1'b1, `OFF_FIELD_LEN, 32'(fl));
    apb(1'b1, `OFF_REC_LOC, 32'h40);
    apb(1'b1, `OFF_MASK, 32'h1F);
    // every selection pattern against every error kind
    for (int m = 0; m < 8; m++) begin
      apb(1'b1, `OFF_EXIT_MODE, 32'(m));
      mode = m;
      for (int k = 0; k < 17; k++) begin
        a = 18'($urandom_range(fl, 'h3FFFF));
        case (k)
          0: {incr_write_req, incr_write_addr} <= {1'b1, 18'(fl - 1)};
          1: {incr_write_req, incr_write_addr} <= {1'b1, a};
          2: {next_instruction_fetch, fetch_addr} <= {1'b1, 18'(fl)};
          3: {compare_move_unit, first_char_position, second_char_position} <= {1'b1, 4'h9, 4'hA};
          4: {compare_move_unit, first_operand_address, second_operand_address} <= {1'b1, 18'(fl - 1), a};
          5: {compare_move_unit, first_char_position, second_char_position} <= {1'b1, 4'h9, 4'h9};
          6, 7, 8, 9: {extended_memory, uem_range_fail, uem_opcode} <= {2'b11, ops[k - 6]};
          10: {extended_memory, uem_range_fail, uem_opcode} <= {2'b11, 9'h00B};
          11: fp_infinite <= 1'b1;
          12: fp_indefinite <= 1'b1;
          13: hw_parity_error <= 1'b1;
          14: double_bit_error <= 1'b1;
          15: {hw_parity_error, incr_write_req, incr_write_addr} <= {2'b11, a};
          default: {monitor_flag, double_bit_error} <= 2'b01;
        endcase
        fire();
        if (k == 1 && mode[0]) begin
          chk(48'(out_of_range_address), 48'(a));
        end
      end
    end
    $display("error path sweep done");
    apb(1'b0, `OFF_STATUS, 32'h0);
    chk(48'({irq, rd}), 48'({1'b1, 32'h1F}));
    apb(1'b1, `OFF_MASK, 32'h0);
    @(negedge pclk);
    chk(48'(irq), 48'h0);
    apb(1'b1, `OFF_MASK, 32'h1F);
    apb(1'b1, `OFF_STATUS, 32'h1F);
    apb(1'b0, `OFF_STATUS, 32'h0);
    chk(48'({irq, rd}), 48'h0);
    $display("interrupt test done");
    complete_run();
  end
endmodule : cp_monitor_mode_error_exit_bench
`default_nettype wire
